// ---- rtl/itsr_pkg.sv ----
/*
  Shared constants of the inductance threshold and status register block:
  register offsets, reset values, status bit positions and mode codes.
  Assumes an 8-bit register port with 8-bit addresses on one clock.
*/
package itsr_pkg;
  // ==========================================================
  // Register offsets
  localparam logic [7:0] OFS_IRQ_SOURCE_SELECT = 8'h0A;
  localparam logic [7:0] OFS_OPERATING_MODE = 8'h0B;
  localparam logic [7:0] OFS_INDUCT_UPPER_LOW = 8'h16;
  localparam logic [7:0] OFS_INDUCT_UPPER_HIGH = 8'h17;
  localparam logic [7:0] OFS_INDUCT_LOWER_LOW = 8'h18;
  localparam logic [7:0] OFS_INDUCT_LOWER_HIGH = 8'h19;
  localparam logic [7:0] OFS_STATUS = 8'h20;

  // ==========================================================
  // Reset values
  localparam logic [7:0] RST_LIMIT_BYTE = 8'h00;
  localparam logic [5:0] RST_IRQ_SOURCE_SELECT = 6'h00;
  localparam logic [1:0] RST_OPERATING_MODE = 2'h1;
  localparam logic RST_STATUS_FLAG = 1'h0;
  // Value written to the source select register that clears latched flags
  localparam logic [7:0] LATCH_CLEAR_VALUE = 8'h00;

  // ==========================================================
  // Status bit positions
  localparam int STS_OSC_LOST = 7;
  localparam int STS_READY_N = 6;
  localparam int STS_RESIST_UPPER = 5;
  localparam int STS_RESIST_HYST = 4;
  localparam int STS_INDUCT_UPPER = 3;
  localparam int STS_INDUCT_HYST = 2;
  localparam int STS_RESERVED = 1;
  localparam int STS_POR_BUSY = 0;

  // ==========================================================
  // Interrupt source select codes
  localparam logic [5:0] IRQ_SEL_NONE = 6'h00;
  localparam logic [5:0] IRQ_SEL_RESIST_LATCH = 6'h01;
  localparam logic [5:0] IRQ_SEL_RESIST_HYST = 6'h02;
  localparam logic [5:0] IRQ_SEL_INDUCT_LATCH = 6'h08;
  localparam logic [5:0] IRQ_SEL_INDUCT_HYST = 6'h10;

  // Operating mode codes
  typedef enum logic [1:0]
  {
    MODE_ACTIVE = 2'h0,
    MODE_SLEEP = 2'h1,
    MODE_SHUTDOWN = 2'h2,
    MODE_RESERVED = 2'h3
  } itsr_mode_type;
endpackage : itsr_pkg

// ---- rtl/itsr_limit_pair.sv ----
/*
  One 16-bit threshold built from two byte registers. The low byte is
  held in a buffer and only joins the active threshold when the high
  byte is written. Assumes write strobes are one-cycle pulses.
*/
`timescale 1ns/1ps
module itsr_limit_pair
(
  input wire logic clk,
  input wire logic rst,
  input wire logic wrLow,
  input wire logic wrHigh,
  input wire logic [7:0] wrData,
  output logic [7:0] lowBuf_reg,
  output logic [7:0] high_reg,
  output logic [15:0] limit_reg
);
  // ==========================================================
  // Next values
  logic [7:0] lowBuf_next;
  logic [7:0] high_next;
  logic [15:0] limit_next;

  // Buffer the low byte, commit both on the high byte write
  always_comb
  begin
    lowBuf_next = lowBuf_reg;
    high_next = high_reg;
    limit_next = limit_reg;
    if (wrLow)
    begin
      lowBuf_next = wrData;
    end
    if (wrHigh)
    begin
      high_next = wrData;
      // Active value is high times 256 plus the buffered low byte
      limit_next = {wrData, lowBuf_reg};
    end
  end

  // Registers
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      lowBuf_reg <= itsr_pkg::RST_LIMIT_BYTE;
      high_reg <= itsr_pkg::RST_LIMIT_BYTE;
      limit_reg <= {itsr_pkg::RST_LIMIT_BYTE, itsr_pkg::RST_LIMIT_BYTE};
    end
    else
    begin
      lowBuf_reg <= lowBuf_next;
      high_reg <= high_next;
      limit_reg <= limit_next;
    end
  end
endmodule : itsr_limit_pair

// ---- rtl/itsr_top.sv ----
/*
  Register side of an inductance-to-digital converter: the inductance
  thresholds, the comparator flags and the status register.
  Assumes the serial port decoder delivers one-cycle read and write
  strobes on clk, and the conversion engines deliver results with a
  one-cycle valid pulse on the same clock.
*/
// What this block does
// (RQ1) Upper limit is high*256 plus low, resets zero
// (RQ2) Result above upper limit lowers upper flag
// (RQ3) Upper low byte buffered until high written
// (RQ4) Lower limit is high*256 plus low, resets zero
// (RQ5) Result below lower limit sets hysteresis flag
// (RQ6) Lower low byte buffered until high written
// (RQ7) Limit writes accepted during active conversion
// (RQ8) Status read-only at 0x20, bit1 zero
// (RQ9) Bit 7 shows oscillation lost
// (RQ10) Bit 6 low when new result exists
// (RQ11) Latched flags cleared by writing 0x00 to 0x0A
// (RQ12) Bit 5 resistance latch, reported when selected
// (RQ13) Bit 3 inductance latch, reported when selected
// (RQ14) Bit 4 resistance hysteresis comparator
// (RQ15) Bit 2 inductance hysteresis comparator
// (RQ16) Bit 0 shows reset busy, writes ignored
// (RQ17) Source select codes choose comparison kind
// (RQ18) Mode codes active, sleep default, shutdown
// (RQ19) Compare once per result, hold between limits
`timescale 1ns/1ps
module itsr_top
(
  input wire logic clk,
  input wire logic rst,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic regWrEn,
  input wire logic regRdEn,
  output logic [7:0] regRdData,
  input wire logic resultValid,
  input wire logic [15:0] inductResult,
  input wire logic [15:0] resistResult,
  input wire logic [15:0] resistUpperLimit,
  input wire logic [15:0] resistLowerLimit,
  input wire logic oscillationLost,
  input wire logic porBusy,
  output logic [5:0] irqSourceSelect,
  output itsr_pkg::itsr_mode_type operatingMode,
  output logic [15:0] inductUpperLimit,
  output logic [15:0] inductLowerLimit
);
  // ==========================================================
  // Write decode
  logic wrOk; // Writes pass only once reset has finished
  logic wrUpperLow;
  logic wrUpperHigh;
  logic wrLowerLow;
  logic wrLowerHigh;
  logic wrSelect;
  logic wrMode;
  logic latchClear; // Host clears the latched flags
  logic compareEn; // One result to compare, in active mode

  // Operating mode never blocks limit writes, only reset does
  assign wrOk = regWrEn && !porBusy; // RQ16 RQ7
  assign wrUpperLow = wrOk && (regAddr == itsr_pkg::OFS_INDUCT_UPPER_LOW);
  assign wrUpperHigh = wrOk && (regAddr == itsr_pkg::OFS_INDUCT_UPPER_HIGH);
  assign wrLowerLow = wrOk && (regAddr == itsr_pkg::OFS_INDUCT_LOWER_LOW);
  assign wrLowerHigh = wrOk && (regAddr == itsr_pkg::OFS_INDUCT_LOWER_HIGH);
  assign wrSelect = wrOk && (regAddr == itsr_pkg::OFS_IRQ_SOURCE_SELECT);
  assign wrMode = wrOk && (regAddr == itsr_pkg::OFS_OPERATING_MODE);
  assign latchClear = wrSelect && (regWrData == itsr_pkg::LATCH_CLEAR_VALUE); // RQ11
  assign compareEn = resultValid && (operatingMode == itsr_pkg::MODE_ACTIVE); // RQ19 RQ18

  // ==========================================================
  // Threshold byte pairs
  logic [7:0] upperLowBuf;
  logic [7:0] upperHigh;
  logic [7:0] lowerLowBuf;
  logic [7:0] lowerHigh;

  // Upper inductance threshold
  itsr_limit_pair upperPair
  (
    .clk(clk),
    .rst(rst),
    .wrLow(wrUpperLow), // RQ3
    .wrHigh(wrUpperHigh), // RQ1
    .wrData(regWrData),
    .lowBuf_reg(upperLowBuf),
    .high_reg(upperHigh),
    .limit_reg(inductUpperLimit)
  );

  // Lower inductance threshold
  itsr_limit_pair lowerPair
  (
    .clk(clk),
    .rst(rst),
    .wrLow(wrLowerLow), // RQ6
    .wrHigh(wrLowerHigh), // RQ4
    .wrData(regWrData),
    .lowBuf_reg(lowerLowBuf),
    .high_reg(lowerHigh),
    .limit_reg(inductLowerLimit)
  );

  // ==========================================================
  // Configuration registers
  logic [5:0] irqSourceSelect_next;
  itsr_pkg::itsr_mode_type operatingMode_next;

  // Source select and mode follow host writes
  always_comb
  begin
    irqSourceSelect_next = irqSourceSelect;
    operatingMode_next = operatingMode;
    if (wrSelect)
    begin
      irqSourceSelect_next = regWrData[5:0]; // RQ17
    end
    if (wrMode)
    begin
      operatingMode_next = itsr_pkg::itsr_mode_type'(regWrData[1:0]); // RQ18
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      irqSourceSelect <= itsr_pkg::RST_IRQ_SOURCE_SELECT;
      operatingMode <= itsr_pkg::itsr_mode_type'(itsr_pkg::RST_OPERATING_MODE); // RQ18
    end
    else
    begin
      irqSourceSelect <= irqSourceSelect_next;
      operatingMode <= operatingMode_next;
    end
  end

  // ==========================================================
  // Comparator flags
  logic inductUpperLatchedFlag_reg;
  logic inductUpperLatchedFlag_next;
  logic resistUpperLatchedFlag_reg;
  logic resistUpperLatchedFlag_next;
  logic inductHystFlag_reg;
  logic inductHystFlag_next;
  logic resistHystFlag_reg;
  logic resistHystFlag_next;
  logic resultReadyN_reg;
  logic resultReadyN_next;
  logic inductAbove;
  logic inductBelow;
  logic resistAbove;
  logic resistBelow;

  assign inductAbove = inductResult > inductUpperLimit; // RQ2
  assign inductBelow = inductResult < inductLowerLimit; // RQ5
  assign resistAbove = resistResult > resistUpperLimit;
  assign resistBelow = resistResult < resistLowerLimit;

  // Hysteresis flags move only on a compared result; a low latch beats a clear
  always_comb
  begin
    inductUpperLatchedFlag_next = inductUpperLatchedFlag_reg;
    resistUpperLatchedFlag_next = resistUpperLatchedFlag_reg;
    inductHystFlag_next = inductHystFlag_reg;
    resistHystFlag_next = resistHystFlag_reg;
    resultReadyN_next = resultReadyN_reg;
    // Clear first so that a same-cycle trigger overrides it
    if (latchClear)
    begin
      inductUpperLatchedFlag_next = 1'h1; // RQ11
      resistUpperLatchedFlag_next = 1'h1; // RQ11
    end
    if (compareEn && inductAbove && irqSourceSelect == itsr_pkg::IRQ_SEL_INDUCT_LATCH)
    begin
      inductUpperLatchedFlag_next = 1'h0; // RQ13 RQ2
    end
    if (compareEn && resistAbove && irqSourceSelect == itsr_pkg::IRQ_SEL_RESIST_LATCH)
    begin
      resistUpperLatchedFlag_next = 1'h0; // RQ12
    end
    // Hysteresis holds while the result sits between the limits
    if (compareEn && inductAbove)
    begin
      inductHystFlag_next = 1'h0; // RQ15
    end
    else if (compareEn && inductBelow)
    begin
      inductHystFlag_next = 1'h1; // RQ15 RQ5
    end
    if (compareEn && resistAbove)
    begin
      resistHystFlag_next = 1'h0; // RQ14
    end
    else if (compareEn && resistBelow)
    begin
      resistHystFlag_next = 1'h1; // RQ14
    end
    // A status read consumes the ready indication, new data wins
    if (resultValid)
    begin
      resultReadyN_next = 1'h0; // RQ10
    end
    else if (regRdEn && regAddr == itsr_pkg::OFS_STATUS)
    begin
      resultReadyN_next = 1'h1; // RQ10
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      inductUpperLatchedFlag_reg <= itsr_pkg::RST_STATUS_FLAG;
      resistUpperLatchedFlag_reg <= itsr_pkg::RST_STATUS_FLAG;
      inductHystFlag_reg <= itsr_pkg::RST_STATUS_FLAG;
      resistHystFlag_reg <= itsr_pkg::RST_STATUS_FLAG;
      resultReadyN_reg <= itsr_pkg::RST_STATUS_FLAG;
    end
    else
    begin
      inductUpperLatchedFlag_reg <= inductUpperLatchedFlag_next;
      resistUpperLatchedFlag_reg <= resistUpperLatchedFlag_next;
      inductHystFlag_reg <= inductHystFlag_next;
      resistHystFlag_reg <= resistHystFlag_next;
      resultReadyN_reg <= resultReadyN_next;
    end
  end

  // ==========================================================
  // Status word and read mux
  logic [7:0] statusWord;
  logic [7:0] regRdData_next;

  always_comb
  begin
    statusWord = 8'h00; // RQ8
    statusWord[itsr_pkg::STS_OSC_LOST] = oscillationLost; // RQ9
    statusWord[itsr_pkg::STS_READY_N] = resultReadyN_reg; // RQ10
    statusWord[itsr_pkg::STS_RESIST_UPPER] = resistUpperLatchedFlag_reg; // RQ12
    statusWord[itsr_pkg::STS_RESIST_HYST] = resistHystFlag_reg; // RQ14
    statusWord[itsr_pkg::STS_INDUCT_UPPER] = inductUpperLatchedFlag_reg; // RQ13
    statusWord[itsr_pkg::STS_INDUCT_HYST] = inductHystFlag_reg; // RQ15
    statusWord[itsr_pkg::STS_POR_BUSY] = porBusy; // RQ16
  end

  // Read data is registered; unmapped offsets read zero
  always_comb
  begin
    regRdData_next = regRdData;
    if (regRdEn)
    begin
      if (regAddr == itsr_pkg::OFS_INDUCT_UPPER_LOW)
        regRdData_next = upperLowBuf;
      else if (regAddr == itsr_pkg::OFS_INDUCT_UPPER_HIGH)
        regRdData_next = upperHigh;
      else if (regAddr == itsr_pkg::OFS_INDUCT_LOWER_LOW)
        regRdData_next = lowerLowBuf;
      else if (regAddr == itsr_pkg::OFS_INDUCT_LOWER_HIGH)
        regRdData_next = lowerHigh;
      else if (regAddr == itsr_pkg::OFS_IRQ_SOURCE_SELECT)
        regRdData_next = {2'h0, irqSourceSelect};
      else if (regAddr == itsr_pkg::OFS_OPERATING_MODE)
        regRdData_next = {6'h00, operatingMode};
      else if (regAddr == itsr_pkg::OFS_STATUS)
        regRdData_next = statusWord; // RQ8
      else
        regRdData_next = 8'h00;
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      regRdData <= 8'h00;
    else
      regRdData <= regRdData_next;
  end

  // ==========================================================
  // Assertions
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  AST_UPPER_COMMIT: assert property (wrUpperHigh |=> inductUpperLimit == {$past(regWrData), $past(upperLowBuf)}) // RQ1
    else $error("upper limit not committed from both bytes");
  AST_UPPER_LOW_BUFFERED: assert property (!wrUpperHigh |=> $stable(inductUpperLimit)) // RQ3
    else $error("upper limit changed without high byte write");
  AST_LOWER_LOW_BUFFERED: assert property (!wrLowerHigh |=> $stable(inductLowerLimit)) // RQ6
    else $error("lower limit changed without high byte write");
  AST_LOWER_COMMIT: assert property (wrLowerHigh |=> inductLowerLimit == {$past(regWrData), $past(lowerLowBuf)}) // RQ4
    else $error("lower limit not committed from both bytes");
  AST_ACTIVE_WRITE: assert property (regWrEn && !porBusy && regAddr == itsr_pkg::OFS_INDUCT_UPPER_LOW
    && operatingMode == itsr_pkg::MODE_ACTIVE |=> upperLowBuf == $past(regWrData)) // RQ7
    else $error("limit write refused in active mode");
  AST_POR_BLOCKS: assert property (porBusy && regWrEn |=> $stable(irqSourceSelect) && $stable(inductLowerLimit)) // RQ16
    else $error("configuration changed during reset");
  AST_INDUCT_LATCH: assert property (compareEn && inductAbove && irqSourceSelect == itsr_pkg::IRQ_SEL_INDUCT_LATCH
    |=> !inductUpperLatchedFlag_reg) // RQ13
    else $error("inductance latch not lowered");
  AST_LATCH_HOLDS: assert property (!inductUpperLatchedFlag_reg && !latchClear |=> !inductUpperLatchedFlag_reg) // RQ11
    else $error("inductance latch released without clear");
  AST_HYST_HIGH: assert property (compareEn && inductBelow && !inductAbove |=> inductHystFlag_reg) // RQ5
    else $error("hysteresis flag not set below lower limit");
  AST_HYST_HOLD: assert property (!compareEn |=> $stable(inductHystFlag_reg) && $stable(resistHystFlag_reg)) // RQ19
    else $error("hysteresis flag moved without result");
  AST_STATUS_READ: assert property (regRdEn && regAddr == itsr_pkg::OFS_STATUS
    |=> regRdData[itsr_pkg::STS_RESERVED] == 1'h0 && regRdData[itsr_pkg::STS_POR_BUSY] == $past(porBusy)) // RQ8
    else $error("status read wrong");
  AST_READY_LOW: assert property (resultValid |=> !resultReadyN_reg ##1 1'h1) // RQ10
    else $error("ready flag not low after result");

  COV_LATCH_CLEAR: cover property (!inductUpperLatchedFlag_reg ##1 latchClear ##1 inductUpperLatchedFlag_reg);
  COV_UPPER_PAIR: cover property (wrUpperLow ##[1:4] wrUpperHigh);
  COV_HYST_SWING: cover property (!inductHystFlag_reg ##[1:20] inductHystFlag_reg);
endmodule : itsr_top

// ---- verif/itsr_host_model.sv ----
/*
  Host-side model of the register port: one-cycle write and read strobes.
  Assumes the testbench calls its tasks one at a time from one process.
*/
`timescale 1ns/1ps
module itsr_host_model
(
  input wire logic clk,
  input wire logic porBusy,
  input wire logic [7:0] regRdData,
  output logic [7:0] regAddr,
  output logic [7:0] regWrData,
  output logic regWrEn,
  output logic regRdEn,
  output logic stalled
);
  // ==========================================================
  // Idle values
  initial
  begin
    regAddr = 8'h00;
    regWrData = 8'h00;
    regWrEn = 1'b0;
    regRdEn = 1'b0;
    stalled = 1'b0;
  end

  // ==========================================================
  // Bounded wait for the device to leave its power-on reset
  task automatic wait_por(input bit rude);
    int n;
    n = 0;
    while (!rude && porBusy !== 1'b0 && n < 200)
    begin
      @(posedge clk);
      n++;
    end
    // A stall is reported, never hidden
    if (n >= 200)
      stalled <= 1'b1;
  endtask : wait_por

  // One write strobe; a rude call skips the reset wait on purpose
  task automatic wr(input logic [7:0] a, input logic [7:0] d, input bit rude);
    wait_por(rude);
    @(posedge clk);
    regAddr <= a;
    regWrData <= d;
    regWrEn <= 1'b1;
    @(posedge clk);
    regWrEn <= 1'b0;
    // Released bus shows the inverse so stale values cannot pass
    regAddr <= ~a;
    regWrData <= ~d;
  endtask : wr

  // Clearing the latched comparator flags
  task automatic clear_latched();
    wr(itsr_pkg::OFS_IRQ_SOURCE_SELECT, itsr_pkg::LATCH_CLEAR_VALUE, 1'b0);
  endtask : clear_latched

  // One read strobe; data is taken mid-cycle after the answer edge
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    regAddr <= a;
    regRdEn <= 1'b1;
    @(posedge clk);
    regRdEn <= 1'b0;
    regAddr <= ~a;
    @(negedge clk);
    d = regRdData;
  endtask : rd
endmodule : itsr_host_model

// ---- verif/inductance_threshold_status_tb.sv ----
/*
  Self-checking bench of itsr_top: reference state kept in variables,
  expectations from functions. Assumes the host model drives the port.
*/
`timescale 1ns/1ps
`define CHK(nm, ex, gt) begin checked++; if ((gt) !== (ex)) begin n_errors++; $display("mismatch %s expected %h seen %h", nm, ex, gt); end end
module inductance_threshold_status_tb;
  // ==========================================================
  // Design signals
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] regAddr, regWrData, regRdData;
  logic regWrEn, regRdEn, hostStalled;
  logic resultValid = 1'b0;
  logic [15:0] inductResult = 16'h0000;
  logic [15:0] resistResult = 16'h0000;
  logic [15:0] resistUpperLimit = 16'h0000;
  logic [15:0] resistLowerLimit = 16'h0000;
  logic oscillationLost = 1'b0;
  logic porBusy = 1'b0;
  logic [5:0] irqSourceSelect;
  itsr_pkg::itsr_mode_type operatingMode;
  logic [15:0] inductUpperLimit, inductLowerLimit;
  int n_errors = 0;
  int checked = 0;
  // Reference state
  logic [7:0] upLo, upHi, loLo, loHi, rdv, ra;
  logic [15:0] upAct, loAct, l;
  logic [5:0] sel;
  logic [1:0] mode;
  logic readyN, rUp, rHyst, iUp, iHyst;
  logic [5:0] codes [5] = '{6'h00, 6'h01, 6'h02, 6'h08, 6'h10};

  always #25 clk = ~clk;

  itsr_top i_dut(.clk(clk), .rst(rst), .regAddr(regAddr), .regWrData(regWrData), .regWrEn(regWrEn),
    .regRdEn(regRdEn), .regRdData(regRdData), .resultValid(resultValid), .inductResult(inductResult),
    .resistResult(resistResult), .resistUpperLimit(resistUpperLimit), .resistLowerLimit(resistLowerLimit),
    .oscillationLost(oscillationLost), .porBusy(porBusy), .irqSourceSelect(irqSourceSelect),
    .operatingMode(operatingMode), .inductUpperLimit(inductUpperLimit), .inductLowerLimit(inductLowerLimit));
  itsr_host_model i_host(.clk(clk), .porBusy(porBusy), .regRdData(regRdData), .regAddr(regAddr),
    .regWrData(regWrData), .regWrEn(regWrEn), .regRdEn(regRdEn), .stalled(hostStalled));

  // ==========================================================
  // Expectation functions
  // Above upper wins; between the limits the flag holds
  function automatic logic hyst(input logic old, input logic [15:0] v, input logic [15:0] up,
    input logic [15:0] lo);
    return (v > up) ? 1'b0 : ((v < lo) ? 1'b1 : old);
  endfunction : hyst
  // Latched flag only drops while its own source is selected
  function automatic logic latch(input logic old, input logic [15:0] v, input logic [15:0] up,
    input logic [5:0] s, input logic [5:0] code);
    return (s == code && v > up) ? 1'b0 : old;
  endfunction : latch
  // Readback of a limit byte: low bytes return the buffered value
  function automatic logic [7:0] exp_byte(input logic [7:0] a);
    return (a == 8'h16) ? upLo : ((a == 8'h17) ? upHi : ((a == 8'h18) ? loLo : loHi));
  endfunction : exp_byte
  function automatic logic [7:0] exp_status();
    return {oscillationLost, readyN, rUp, rHyst, iUp, iHyst, 1'b0, porBusy};
  endfunction : exp_status

  // ==========================================================
  // Verdict, reached from the main sequence or the watchdog
  task automatic report_and_stop();
    if (n_errors == 0 && checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : report_and_stop

  // Write through the host and track what the device must hold
  task automatic w(input logic [7:0] a, input logic [7:0] d);
    i_host.wr(a, d, 1'b0);
    case (a)
      8'h16: upLo = d;
      8'h17:
      begin
        upHi = d;
        upAct = {d, upLo};
      end
      8'h18: loLo = d;
      8'h19:
      begin
        loHi = d;
        loAct = {d, loLo};
      end
      8'h0A:
      begin
        sel = d[5:0];
        // Writing zero re-arms both latched flags
        if (d == 8'h00)
        begin
          rUp = 1'b1;
          iUp = 1'b1;
        end
      end
      8'h0B: mode = d[1:0];
      default: ;
    endcase
  endtask : w

  // One conversion result; compared only in active mode
  task automatic conv(input logic [15:0] li, input logic [15:0] r, input logic [15:0] ru, input logic [15:0] rl);
    @(posedge clk);
    resultValid <= 1'b1;
    inductResult <= li;
    resistResult <= r;
    resistUpperLimit <= ru;
    resistLowerLimit <= rl;
    @(posedge clk);
    resultValid <= 1'b0;
    inductResult <= ~li;
    resistResult <= ~r;
    readyN = 1'b0;
    if (mode == 2'h0)
    begin
      iHyst = hyst(iHyst, li, upAct, loAct);
      rHyst = hyst(rHyst, r, ru, rl);
      iUp = latch(iUp, li, upAct, sel, itsr_pkg::IRQ_SEL_INDUCT_LATCH);
      rUp = latch(rUp, r, ru, sel, itsr_pkg::IRQ_SEL_RESIST_LATCH);
    end
  endtask : conv

  // Status read and port checks; the read re-arms the ready flag
  task automatic check_all();
    i_host.rd(8'h20, rdv);
    `CHK("status", exp_status(), rdv)
    readyN = 1'b1;
    `CHK("upper", upAct, inductUpperLimit)
    `CHK("lower", loAct, inductLowerLimit)
    `CHK("select", sel, irqSourceSelect)
    `CHK("mode", mode, operatingMode)
  endtask : check_all

  // ==========================================================
  // Watchdog against a hang
  initial
  begin
    repeat (60000) @(posedge clk);
    n_errors++;
    report_and_stop();
  end

  // ==========================================================
  // Main sequence
  initial
  begin
    {upLo, upHi, loLo, loHi, upAct, loAct, sel} = '0;
    {readyN, rUp, rHyst, iUp, iHyst} = '0;
    mode = 2'h1;
    void'($urandom(82));
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    // Reset values of the limit bytes and status
    for (int a = 8'h16; a <= 8'h19; a++)
    begin
      i_host.rd(8'(a), rdv);
      `CHK("limitByte", 8'h00, rdv)
    end
    check_all();
    // Low bytes stay buffered until the high byte lands, in active mode
    w(8'h0B, 8'h00);
    w(8'h16, 8'h34);
    w(8'h18, 8'h78);
    `CHK("upperHeld", 16'h0000, inductUpperLimit)
    `CHK("lowerHeld", 16'h0000, inductLowerLimit)
    i_host.rd(8'h16, rdv);
    `CHK("upperLowByte", 8'h34, rdv)
    w(8'h17, 8'h12);
    w(8'h19, 8'h05);
    check_all();
    // Latched inductance flag, hysteresis and clear; arm the latches first
    w(8'h0A, 8'h00);
    w(8'h0A, 8'h08);
    i_host.rd(8'h0A, rdv);
    `CHK("selectByte", {2'h0, sel}, rdv)
    conv(16'h1235, 16'h0000, 16'hFFFF, 16'h0000);
    check_all();
    conv(16'h0100, 16'h0000, 16'hFFFF, 16'h0000);
    check_all();
    i_host.clear_latched();
    w(8'h0A, 8'h00);
    check_all();
    // Status is read-only; unmapped reads give zero
    w(8'h20, 8'hFF);
    check_all();
    i_host.rd(8'h55, rdv);
    `CHK("unmapped", 8'h00, rdv)
    // Oscillation loss shows in bit 7
    @(posedge clk);
    oscillationLost <= 1'b1;
    check_all();
    @(posedge clk);
    oscillationLost <= 1'b0;
    // Writes are dropped while reset is in progress
    @(posedge clk);
    porBusy <= 1'b1;
    i_host.wr(8'h17, 8'h5A, 1'b1);
    check_all();
    @(posedge clk);
    porBusy <= 1'b0;
    // Every mode code that holds a meaning
    for (int m = 2; m >= 0; m--)
    begin
      w(8'h0B, 8'(m));
      check_all();
      i_host.rd(8'h0B, rdv);
      `CHK("modeByte", {6'h00, mode}, rdv)
    end
    // Random traffic with corner results around both limits
    repeat (300)
    begin
      case ($urandom_range(0, 6))
        0: w(8'h16 + 8'($urandom_range(0, 3)), 8'($urandom));
        1: w(8'h0A, {2'b00, codes[$urandom_range(0, 4)]});
        2: w(8'h0B, ($urandom_range(0, 3) == 0) ? 8'h01 : 8'h00);
        3, 4:
        begin
          case ($urandom_range(0, 4))
            0: l = upAct;
            1: l = upAct + 16'h0001;
            2: l = loAct;
            3: l = loAct - 16'h0001;
            default: l = 16'($urandom);
          endcase
          conv(l, 16'($urandom), 16'($urandom_range(16'h8000, 16'hFFFF)), 16'($urandom_range(0, 16'h7FFF)));
        end
        5:
        begin
          ra = 8'h16 + 8'($urandom_range(0, 3));
          i_host.rd(ra, rdv);
          `CHK("limitByte", exp_byte(ra), rdv)
        end
        default: check_all();
      endcase
    end
    check_all();
    `CHK("hostStalled", 1'b0, hostStalled)
    report_and_stop();
  end
endmodule : inductance_threshold_status_tb
